//--- src/tap_pkg.sv
// What this block does
// - tap controller is a sixteen-state machine steered by mode select
// - instruction register is six bits wide and selects test and data path
// - five dedicated test pins: clock, mode select, data in, data out, reset
// - active-low test reset forces reset state without a test clock edge
// - mode select and data in are sampled on rising test clock edges
// - serial data out changes on falling test clock edges
// - data out is released except in shift-dr and shift-ir
// - five rising edges with mode select high reach test-logic-reset
// - data in feeds the selected register: scan chain, instruction, id, bypass
// - port follows 1149.1 and gives scan access to dc-coupled pins
// - no ac-coupled test mode; no time-varying test signal generated
// - tester can read an identification value through an id register
// - instruction shifts on rising edges, takes effect only in update-ir
// - bypass, scan chain and id register sit in parallel, instruction selects
// - all-zero opcode is external test, drives latched scan values onto pins
package tap_pkg;
  localparam int IR_W = 6;
  localparam int ID_W = 32;
  localparam logic [IR_W-1:0] OP_EXTEST = 6'h00;
  localparam logic [IR_W-1:0] OP_SAMPLE = 6'h01;
  localparam logic [IR_W-1:0] OP_IDCODE = 6'h02;
  localparam logic [IR_W-1:0] OP_BYPASS = 6'h3F;
  localparam logic [IR_W-1:0] IR_CAPTURE = 6'h01;
  // arbitrary neutral identification value, lsb set as customary
  localparam logic [ID_W-1:0] ID_VALUE = 32'h00000001;

  typedef enum logic [15:0] {
    st_reset = 16'h0001,
    st_idle = 16'h0002,
    st_sel_dr = 16'h0004,
    st_cap_dr = 16'h0008,
    st_shift_dr = 16'h0010,
    st_exit1_dr = 16'h0020,
    st_pause_dr = 16'h0040,
    st_exit2_dr = 16'h0080,
    st_upd_dr = 16'h0100,
    st_sel_ir = 16'h0200,
    st_cap_ir = 16'h0400,
    st_shift_ir = 16'h0800,
    st_exit1_ir = 16'h1000,
    st_pause_ir = 16'h2000,
    st_exit2_ir = 16'h4000,
    st_upd_ir = 16'h8000
  } tap_state_t;
endpackage

//--- src/tap_ctrl.sv
`timescale 1ns/1ps
module tap_ctrl #(
  parameter int CHAIN_LEN = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  output logic tdo,
  output logic tdo_oe,
  input wire logic [CHAIN_LEN-1:0] pin_capture,
  input wire logic [CHAIN_LEN-1:0] core_out,
  output logic [CHAIN_LEN-1:0] pin_out,
  output logic extest_active,
  output tap_pkg::tap_state_t tap_state,
  output logic [tap_pkg::IR_W-1:0] instr
);
  import tap_pkg::*;

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [CHAIN_LEN-1:0] cap_s1;
    logic [CHAIN_LEN-1:0] cap_s2;
    logic tck_prev;
    tap_state_t state;
    logic [IR_W-1:0] ir_shift;
    logic [IR_W-1:0] ir;
    logic [CHAIN_LEN-1:0] chain_shift;
    logic [CHAIN_LEN-1:0] chain_latch;
    logic [ID_W-1:0] id_shift;
    logic bypass;
    logic tdo;
    logic tdo_oe;
  } tap_regs_t;

  tap_regs_t r_reg;
  tap_regs_t r_next;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  function automatic tap_state_t step(input tap_state_t s, input logic m);
    tap_state_t n;
    n = st_reset;
    case (s)
      st_reset: n = m ? st_reset : st_idle;
      st_idle: n = m ? st_sel_dr : st_idle;
      st_sel_dr: n = m ? st_sel_ir : st_cap_dr;
      st_cap_dr: n = m ? st_exit1_dr : st_shift_dr;
      st_shift_dr: n = m ? st_exit1_dr : st_shift_dr;
      st_exit1_dr: n = m ? st_upd_dr : st_pause_dr;
      st_pause_dr: n = m ? st_exit2_dr : st_pause_dr;
      st_exit2_dr: n = m ? st_upd_dr : st_shift_dr;
      st_upd_dr: n = m ? st_sel_dr : st_idle;
      st_sel_ir: n = m ? st_reset : st_cap_ir;
      st_cap_ir: n = m ? st_exit1_ir : st_shift_ir;
      st_shift_ir: n = m ? st_exit1_ir : st_shift_ir;
      st_exit1_ir: n = m ? st_upd_ir : st_pause_ir;
      st_pause_ir: n = m ? st_exit2_ir : st_pause_ir;
      st_exit2_ir: n = m ? st_upd_ir : st_shift_ir;
      st_upd_ir: n = m ? st_sel_dr : st_idle;
      default: n = st_reset;
    endcase
    return n;
  endfunction

  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic trst_s_n;
  logic rise;
  logic fall;
  logic sel_chain;
  logic sel_id;
  logic dr_out;

  assign tck_s = r_reg.s2[0];
  assign tms_s = r_reg.s2[1];
  assign tdi_s = r_reg.s2[2];
  assign trst_s_n = r_reg.s2[3];
  assign rise = tck_s & ~r_reg.tck_prev;
  assign fall = ~tck_s & r_reg.tck_prev;
  // only one data register on the path at a time
  assign sel_chain = (r_reg.ir == OP_EXTEST) || (r_reg.ir == OP_SAMPLE);
  assign sel_id = (r_reg.ir == OP_IDCODE);
  assign dr_out = sel_chain ? r_reg.chain_shift[0] :
                  sel_id ? r_reg.id_shift[0] : r_reg.bypass;

  // ----------------------------------------------------------------
  // combinational update of the whole state
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.s1 = {trst_n, tdi, tms, tck};
    r_next.s2 = r_reg.s1;
    // pad values are asynchronous to core_clk
    r_next.cap_s1 = pin_capture;
    r_next.cap_s2 = r_reg.cap_s1;
    r_next.tck_prev = tck_s;
    if (!trst_s_n) begin
      // test reset acts with no test clock edge
      r_next.state = st_reset;
      r_next.ir = OP_IDCODE;
      r_next.tdo_oe = 1'b0;
    end else begin
      if (rise) begin
        r_next.state = step(r_reg.state, tms_s);
        case (r_reg.state)
          st_cap_ir: r_next.ir_shift = IR_CAPTURE;
          st_shift_ir: r_next.ir_shift = {tdi_s, r_reg.ir_shift[IR_W-1:1]};
          st_cap_dr: begin
            r_next.chain_shift = r_reg.cap_s2;
            r_next.id_shift = ID_VALUE;
            r_next.bypass = 1'b0;
          end
          st_shift_dr: begin
            // data in feeds only the selected register
            if (sel_chain) begin
              r_next.chain_shift = {tdi_s, r_reg.chain_shift[CHAIN_LEN-1:1]};
            end else if (sel_id) begin
              r_next.id_shift = {tdi_s, r_reg.id_shift[ID_W-1:1]};
            end else begin
              r_next.bypass = tdi_s;
            end
          end
          default: begin
          end
        endcase
      end
      if (fall) begin
        case (r_reg.state)
          st_reset: r_next.ir = OP_IDCODE;
          st_upd_ir: r_next.ir = r_reg.ir_shift;
          st_upd_dr: begin
            if (sel_chain) begin
              r_next.chain_latch = r_reg.chain_shift;
            end
          end
          default: begin
          end
        endcase
        if (r_reg.state == st_shift_ir) begin
          r_next.tdo = r_reg.ir_shift[0];
          r_next.tdo_oe = 1'b1;
        end else if (r_reg.state == st_shift_dr) begin
          r_next.tdo = dr_out;
          r_next.tdo_oe = 1'b1;
        end else begin
          r_next.tdo_oe = 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      r_reg.s1 <= 4'hF;
      r_reg.s2 <= 4'hF;
      r_reg.cap_s1 <= '0;
      r_reg.cap_s2 <= '0;
      r_reg.tck_prev <= 1'b1;
      r_reg.state <= st_reset;
      r_reg.ir_shift <= IR_CAPTURE;
      r_reg.ir <= OP_IDCODE;
      r_reg.chain_shift <= '0;
      r_reg.chain_latch <= '0;
      r_reg.id_shift <= '0;
      r_reg.bypass <= 1'b0;
      r_reg.tdo <= 1'b0;
      r_reg.tdo_oe <= 1'b0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // dc pins only; no ac test signal is generated for coupled pins
  assign extest_active = (r_reg.ir == OP_EXTEST);
  assign pin_out = extest_active ? r_reg.chain_latch : core_out;
  assign tdo = r_reg.tdo;
  assign tdo_oe = r_reg.tdo_oe;
  assign tap_state = r_reg.state;
  assign instr = r_reg.ir;
endmodule

//--- src/unused_removed.sv
`timescale 1ns/1ps

//--- verif/tap_chk.sv
`timescale 1ns/1ps
module tap_chk import tap_pkg::*; #(parameter int CHAIN_LEN = 16) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic trst_n,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic [CHAIN_LEN-1:0] core_out,
  input wire logic [CHAIN_LEN-1:0] pin_out,
  input wire logic extest_active,
  input wire tap_state_t tap_state,
  input wire logic [IR_W-1:0] instr
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic tck_reg;
  logic [2:0] ones_reg;
  always_ff @(posedge core_clk) begin
    tck_reg <= tck;
    if (rst || !trst_n) begin
      ones_reg <= 3'h0;
    end else if (tck && !tck_reg) begin
      ones_reg <= !tms ? 3'h0 : (ones_reg == 3'h5) ? ones_reg : ones_reg + 3'h1;
    end
  end
  state_onehot_a: assert property ($onehot(tap_state)) else $error("state not one-hot");
  oe_in_shift_a: assert property ($rose(tdo_oe) |-> tap_state inside {st_shift_dr, st_shift_ir})
    else $error("tdo driven outside shift");
  tdo_on_fall_a: assert property ($changed(tdo) |-> !$past(tck))
    else $error("tdo moved while tck high");
  step_on_rise_a: assert property ($changed(tap_state) |-> $past(tck) || tap_state == st_reset)
    else $error("state moved without tck rise");
  trst_reset_a: assert property ($fell(trst_n) |-> ##[1:5] (tap_state == st_reset &&
    instr == OP_IDCODE && !tdo_oe)) else $error("trst did not reset");
  five_ones_a: assert property ($rose(ones_reg == 3'h5) |-> ##[1:6] tap_state == st_reset)
    else $error("five tms ones missed reset");
  instr_update_a: assert property ($changed(instr) |->
    $past(tap_state) == st_upd_ir || tap_state == st_reset) else $error("instr moved early");
  extest_dec_a: assert property (extest_active == (instr == OP_EXTEST))
    else $error("extest not decoded");
  normal_pins_a: assert property (!extest_active |-> pin_out == core_out)
    else $error("pins not from core");
  cover property ($rose(tdo_oe));
  cover property ($rose(extest_active));
  cover property ($fell(trst_n));
  cover property ($rose(ones_reg == 3'h5));
endmodule
bind tap_ctrl tap_chk #(.CHAIN_LEN(CHAIN_LEN)) tap_chk_i (.core_clk(core_clk), .rst(rst),
  .tck(tck), .tms(tms), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .core_out(core_out),
  .pin_out(pin_out), .extest_active(extest_active), .tap_state(tap_state), .instr(instr));

//--- verif/jtag_tester.sv
`timescale 1ns/1ps
module jtag_tester (
  input wire logic core_clk,
  output logic tck = 1'b1,
  output logic tms = 1'b1,
  output logic tdi = 1'b1,
  output logic trst_n = 1'b1,
  input wire logic tdo,
  input wire logic tdo_oe
);
  // one tck period; tck idles high between frames
  task automatic step(input logic m, input logic d, output logic o);
    @(posedge core_clk);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge core_clk);
    o = tdo_oe ? tdo : ~tdo;
    tck <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic hard_reset();
    @(posedge core_clk);
    trst_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    trst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask
endmodule

//--- verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import tap_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic tck, tms, tdi, trst_n, tdo, tdo_oe, extest_active, o;
  logic [15:0] pin_out;
  tap_state_t tap_state;
  logic [IR_W-1:0] instr;
  logic [31:0] d;
  logic [15:0] core_val = 16'h1234;
  int mismatches = 0;
  int checks_done = 0;
  int cyc = 0;
  always #20 core_clk = ~core_clk;
  tap_ctrl #(.CHAIN_LEN(16)) tap_ctrl_i (.core_clk(core_clk), .rst(rst), .tck(tck), .tms(tms),
    .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .pin_capture(16'hA5C3),
    .core_out(core_val), .pin_out(pin_out), .extest_active(extest_active),
    .tap_state(tap_state), .instr(instr));
  jtag_tester jtag_tester_i (.core_clk(core_clk), .tck(tck), .tms(tms), .tdi(tdi),
    .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // from idle: ir or dr scan of n bits, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din);
    d = 32'h0;
    jtag_tester_i.step(1'b1, 1'b0, o);
    if (ir) jtag_tester_i.step(1'b1, 1'b0, o);
    repeat (2) jtag_tester_i.step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) jtag_tester_i.step(i == n - 1, din[i], d[i]);
    jtag_tester_i.step(1'b1, 1'b0, o);
    jtag_tester_i.step(1'b0, 1'b0, o);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic t_idcode();
    chk("state", st_reset, tap_state);
    chk("instr", OP_IDCODE, instr);
    jtag_tester_i.step(1'b0, 1'b0, o);
    scan(1'b0, 32, 32'h0);
    chk("idcode", ID_VALUE, d);
    chk("oe", 1'b0, tdo_oe);
  endtask
  task automatic t_sample();
    scan(1'b1, 6, OP_SAMPLE);
    chk("ir capture", IR_CAPTURE, d[5:0]);
    chk("instr", OP_SAMPLE, instr);
    scan(1'b0, 16, 32'h5A96);
    chk("capture", 16'hA5C3, d[15:0]);
    chk("pins", 16'h1234, pin_out);
  endtask
  task automatic t_extest();
    scan(1'b1, 6, OP_EXTEST);
    chk("extest", 1'b1, extest_active);
    chk("pins", 16'h5A96, pin_out);
    core_val <= 16'hBEEF;
    repeat (2) @(posedge core_clk);
    chk("pins held", 16'h5A96, pin_out);
  endtask
  // unassigned opcodes fall back to the bypass bit
  task automatic t_bypass();
    scan(1'b1, 6, OP_BYPASS);
    chk("extest", 1'b0, extest_active);
    chk("pins", 16'hBEEF, pin_out);
    scan(1'b0, 4, 32'h6);
    chk("bypass", 4'hC, d[3:0]);
    scan(1'b1, 6, 32'h15);
    scan(1'b0, 4, 32'h6);
    chk("bypass other", 4'hC, d[3:0]);
  endtask
  // from shift-dr, the deepest case: exactly five ones needed
  task automatic t_tms_reset();
    jtag_tester_i.step(1'b1, 1'b0, o);
    repeat (2) jtag_tester_i.step(1'b0, 1'b0, o);
    repeat (4) jtag_tester_i.step(1'b1, 1'b0, o);
    @(posedge core_clk);
    chk("state", st_sel_ir, tap_state);
    jtag_tester_i.step(1'b1, 1'b0, o);
    @(posedge core_clk);
    chk("state", st_reset, tap_state);
    jtag_tester_i.step(1'b1, 1'b0, o);
    chk("instr", OP_IDCODE, instr);
  endtask
  task automatic t_trst();
    jtag_tester_i.step(1'b0, 1'b0, o);
    scan(1'b1, 6, OP_BYPASS);
    jtag_tester_i.step(1'b1, 1'b0, o);
    repeat (3) jtag_tester_i.step(1'b0, 1'b0, o);
    chk("state", st_shift_dr, tap_state);
    chk("oe", 1'b1, tdo_oe);
    jtag_tester_i.hard_reset();
    chk("state", st_reset, tap_state);
    chk("instr", OP_IDCODE, instr);
    chk("oe", 1'b0, tdo_oe);
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_idcode();
    t_sample();
    t_extest();
    t_bypass();
    t_tms_reset();
    t_trst();
    report_and_stop();
  end
endmodule
